// file: pkg/hssp_pkg.sv
// package: constants and state type for the hub strap and status pin block
package hssp_pkg;
	localparam int CLK_HZ = 40000000;
	localparam logic MODE_MEMORY = 1'b1;
	localparam logic MODE_HOST = 1'b0;
	localparam logic [6:0] MEM_BUS_ADDR = 7'h50;
	localparam logic [7:0] MEM_START_ADDR = 8'h00;
	localparam logic [3:0] SLAVE_ADDR_HI = 4'h8;
	localparam logic [1:0] SLAVE_ADDR_B32 = 2'h3;
	localparam logic [1:0] SLAVE_ADDR_B0 = 2'h0;
	localparam int SYNC_STAGES = 3;
	localparam int STRAP_SETTLE = 2;
	localparam logic [1:0] STRAP_CNT_RESET = 2'h0;

	typedef enum logic [1:0] {
		HSSP_SETTLE,
		HSSP_CAPTURE,
		HSSP_RUN
	} hssp_state_t;

	typedef struct packed {
		hssp_state_t state;
		logic [1:0] settle_cnt;
		logic [SYNC_STAGES-1:0] mode_sync;
		logic [SYNC_STAGES-1:0] sda_sync;
		logic [SYNC_STAGES-1:0] pwr_sync;
		logic strap_valid;
		logic lpm_strap;
		logic pwr_strap;
		logic mode;
		logic hs_susp;
		logic ss_susp;
		logic hs_link;
		logic ss_link;
		logic lpm_disable;
		logic ds_pwr_en;
	} hssp_regs_t;
endpackage

// file: src/hssp_top.sv
// design: hub strap sampling, serial interface mode select and upstream status pins
// ---------------------------------------------------------------
// Functional notes
// [R1] mode input high routes the shared pins to the memory master, low to the host slave.
// [R2] data pin is sampled at reset release; high disables U1/U2, low enables them.
// [R3] with memory or host configuration, the config disable bit decides U1/U2 instead.
// [R4] high-speed suspend output is 1 while suspended in high speed, else 0.
// [R5] superspeed suspend output is 1 while suspended in superspeed, else 0.
// [R6] high-speed link output is 1 when connected high speed, 0 at low or full speed.
// [R7] superspeed link output is 1 when running superspeed, else 0.
// [R8] power strap sampled at reset release; 0 gives full power management, 1 none.
// [R9] with full power management the downstream power enable output is driven.
// [R10] in host mode the power strap value is slave address bit 1.
// [R11] slave address bits 2 and 3 are always one.
// [R12] the slave answers address 1000 11xy, x the strap, y the read bit.
// [R13] memory mode reads bus address 1010000b, 7-bit addressing, from address 0.
// [R14] straps latch at reset release and hold until the next reset.
// [R15] status outputs follow the link state synchronously to the core clock.
// ---------------------------------------------------------------
`timescale 1ns/10ps
module hssp_top (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic interface_mode_select,
	input wire logic shared_serial_clock_pin_i,
	output logic shared_serial_clock_pin_o,
	output logic shared_serial_clock_pin_oe,
	input wire logic shared_serial_data_pin_i,
	output logic shared_serial_data_pin_o,
	output logic shared_serial_data_pin_oe,
	input wire logic power_mgmt_strap_addr_bit,
	input wire logic cfg_loaded,
	input wire logic cfg_low_power_link_state_disable,
	input wire logic mem_scl_o,
	input wire logic mem_scl_oe,
	input wire logic mem_sda_o,
	input wire logic mem_sda_oe,
	input wire logic host_scl_o,
	input wire logic host_scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	output logic engine_scl_i,
	output logic engine_sda_i,
	output logic memory_mode_en,
	output logic host_mode_en,
	output logic strap_valid,
	output logic [6:0] mem_bus_addr,
	output logic [7:0] mem_start_addr,
	output logic [6:0] slave_addr,
	input wire logic port_pwr_request,
	input wire logic up_connected,
	input wire logic up_high_speed,
	input wire logic up_super_speed,
	input wire logic up_suspended,
	output logic high_speed_suspend_out,
	output logic super_speed_suspend_out,
	output logic high_speed_link_out,
	output logic super_speed_link_out,
	output logic low_power_link_state_disable,
	output logic full_power_mgmt,
	output logic downstream_power_enable
);
	import hssp_pkg::*;

	// ---------------------------------------------------------------
	// state and decoded levels
	// ---------------------------------------------------------------
	hssp_regs_t r_q;
	hssp_regs_t r_d;
	logic sda_agree;
	logic pwr_agree;
	logic settle_done;
	logic hs_now;
	logic ss_now;
	logic hs_susp_now;
	logic ss_susp_now;
	logic cfg_source;
	logic use_mem_pins;
	logic pwr_ctrl_ok;

	// ---------------------------------------------------------------
	// helper functions
	// ---------------------------------------------------------------
	// shift one pin sample into a synchroniser chain
	function automatic logic [SYNC_STAGES-1:0] sync_shift(
		input logic [SYNC_STAGES-1:0] s,
		input logic pin
	);
		sync_shift = {s[SYNC_STAGES-2:0], pin};
	endfunction

	// a pin change counts once the second and third stages agree
	function automatic logic sync_agree(input logic [SYNC_STAGES-1:0] s);
		sync_agree = (s[1] == s[2]);
	endfunction

	// agreed level of a chain, else the level held so far
	function automatic logic sync_level(
		input logic [SYNC_STAGES-1:0] s,
		input logic prev
	);
		sync_level = sync_agree(s) ? s[2] : prev;
	endfunction

	// upstream port connected at high speed and not at superspeed
	function automatic logic link_high_speed(
		input logic conn,
		input logic hs,
		input logic ss
	);
		link_high_speed = conn & hs & ~ss;
	endfunction

	// upstream port connected at superspeed
	function automatic logic link_super_speed(
		input logic conn,
		input logic ss
	);
		link_super_speed = conn & ss;
	endfunction

	// 7-bit slave address 1000 11x; the read/write bit follows on the wire
	function automatic logic [6:0] slave_address(input logic strap);
		slave_address = {SLAVE_ADDR_HI, SLAVE_ADDR_B32, strap};
	endfunction

	// ---------------------------------------------------------------
	// decoded levels
	// ---------------------------------------------------------------
	always_comb begin
		sda_agree = sync_agree(r_q.sda_sync);
		pwr_agree = sync_agree(r_q.pwr_sync);
		settle_done = (r_q.settle_cnt == 2'(STRAP_SETTLE));
		hs_now = link_high_speed(up_connected, up_high_speed, up_super_speed); // [R6]
		ss_now = link_super_speed(up_connected, up_super_speed); // [R7]
		hs_susp_now = hs_now & up_suspended; // [R4]
		ss_susp_now = ss_now & up_suspended; // [R5]
		cfg_source = r_q.strap_valid & cfg_loaded; // [R3]
		use_mem_pins = (r_q.mode == MODE_MEMORY); // [R1]
		pwr_ctrl_ok = r_q.strap_valid & ~r_q.pwr_strap; // [R8] [R9]
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		// synchroniser chains
		r_d.mode_sync = sync_shift(r_q.mode_sync, interface_mode_select);
		r_d.sda_sync = sync_shift(r_q.sda_sync, shared_serial_data_pin_i);
		r_d.pwr_sync = sync_shift(r_q.pwr_sync, power_mgmt_strap_addr_bit);
		// mode follows the agreed pin level
		r_d.mode = sync_level(r_q.mode_sync, r_q.mode); // [R1]
		// strap sequencer
		case (r_q.state)
			HSSP_SETTLE: begin
				if (settle_done) begin
					r_d.state = HSSP_CAPTURE;
				end else begin
					r_d.settle_cnt = r_q.settle_cnt + 2'h1;
				end
			end
			HSSP_CAPTURE: begin
				if (sda_agree & pwr_agree) begin
					r_d.lpm_strap = r_q.sda_sync[2]; // [R2] [R14]
					r_d.pwr_strap = r_q.pwr_sync[2]; // [R8] [R14]
					r_d.strap_valid = 1'b1;
					r_d.state = HSSP_RUN;
				end else begin
					r_d.state = HSSP_CAPTURE;
				end
			end
			HSSP_RUN: begin
				r_d.state = HSSP_RUN; // [R14]
			end
			default: begin
				r_d.state = HSSP_SETTLE;
			end
		endcase
		// status follows the link each core clock
		r_d.hs_susp = hs_susp_now; // [R4] [R15]
		r_d.ss_susp = ss_susp_now; // [R5] [R15]
		r_d.hs_link = hs_now; // [R6] [R15]
		r_d.ss_link = ss_now; // [R7] [R15]
		// low-power link state source
		if (cfg_source) begin
			r_d.lpm_disable = cfg_low_power_link_state_disable; // [R3]
		end else begin
			r_d.lpm_disable = r_q.lpm_strap; // [R2]
		end
		// downstream power switch control
		if (pwr_ctrl_ok) begin
			r_d.ds_pwr_en = port_pwr_request; // [R9]
		end else begin
			r_d.ds_pwr_en = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r_q <= '0;
			r_q.state <= HSSP_SETTLE;
			r_q.settle_cnt <= STRAP_CNT_RESET;
		end else begin
			r_q <= r_d;
		end
	end

	// ---------------------------------------------------------------
	// shared clock pin routing
	// ---------------------------------------------------------------
	// drivers stay off until the straps are taken, so the pins read clean
	always_comb begin
		if (use_mem_pins) begin
			shared_serial_clock_pin_o = mem_scl_o; // [R1]
			shared_serial_clock_pin_oe = mem_scl_oe & r_q.strap_valid;
		end else begin
			shared_serial_clock_pin_o = host_scl_o; // [R1]
			shared_serial_clock_pin_oe = host_scl_oe & r_q.strap_valid;
		end
	end

	// ---------------------------------------------------------------
	// shared data pin routing
	// ---------------------------------------------------------------
	always_comb begin
		if (use_mem_pins) begin
			shared_serial_data_pin_o = mem_sda_o; // [R1]
			shared_serial_data_pin_oe = mem_sda_oe & r_q.strap_valid;
		end else begin
			shared_serial_data_pin_o = host_sda_o; // [R1]
			shared_serial_data_pin_oe = host_sda_oe & r_q.strap_valid;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign engine_scl_i = shared_serial_clock_pin_i;
	assign engine_sda_i = shared_serial_data_pin_i;
	assign memory_mode_en = r_q.strap_valid & (r_q.mode == MODE_MEMORY); // [R1]
	assign host_mode_en = r_q.strap_valid & (r_q.mode == MODE_HOST); // [R1]
	assign strap_valid = r_q.strap_valid;
	assign mem_bus_addr = MEM_BUS_ADDR; // [R13]
	assign mem_start_addr = MEM_START_ADDR; // [R13]
	assign slave_addr = slave_address(r_q.pwr_strap); // [R10] [R11] [R12]
	assign high_speed_suspend_out = r_q.hs_susp;
	assign super_speed_suspend_out = r_q.ss_susp;
	assign high_speed_link_out = r_q.hs_link;
	assign super_speed_link_out = r_q.ss_link;
	assign low_power_link_state_disable = r_q.lpm_disable;
	assign full_power_mgmt = r_q.strap_valid & ~r_q.pwr_strap; // [R8]
	assign downstream_power_enable = r_q.ds_pwr_en;
endmodule // hssp_top

// file: tb/hssp_sva.sv
// checker: port assertions for the hub strap and status block
`timescale 1ns/10ps
module hssp_sva (
	input wire logic clk, reset_n, strap_valid, full_power_mgmt, port_pwr_request,
	input wire logic downstream_power_enable, cfg_loaded, cfg_low_power_link_state_disable,
	input wire logic up_connected, up_high_speed, up_super_speed, up_suspended,
	input wire logic high_speed_suspend_out, super_speed_suspend_out, high_speed_link_out,
	input wire logic super_speed_link_out, low_power_link_state_disable, memory_mode_en,
	input wire logic mem_sda_oe, shared_serial_data_pin_oe,
	input wire logic [6:0] slave_addr
);
	wire hs = up_connected & up_high_speed & ~up_super_speed;
	wire ss = up_connected & up_super_speed;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// registered outputs are judged only once a full cycle has passed since reset
	sequence s_up; $past(reset_n); endsequence
	sequence s_rel; !$past(reset_n); endsequence
	sequence s_held; strap_valid ##1 strap_valid; endsequence
	a_hs_link: assert property (s_up |-> high_speed_link_out == $past(hs))
		else $error("bad hs link");
	a_ss_link: assert property (s_up |-> super_speed_link_out == $past(ss))
		else $error("bad ss link");
	a_hs_susp: assert property (s_up |-> high_speed_suspend_out == $past(hs & up_suspended))
		else $error("bad high_speed_suspend_out");
	a_ss_susp: assert property (s_up |-> super_speed_suspend_out == $past(ss & up_suspended))
		else $error("bad ss suspend");
	a_addr_fix: assert property (slave_addr[6:1] == 6'h23) else $error("bad addr");
	a_addr_strap: assert property (strap_valid |-> slave_addr[0] == !full_power_mgmt)
		else $error("bad addr bit");
	a_strap_hold: assert property (s_held |-> $stable(slave_addr) && $stable(full_power_mgmt))
		else $error("strap moved");
	a_pwr_en: assert property (s_up |-> downstream_power_enable == $past(full_power_mgmt && port_pwr_request))
		else $error("bad power enable");
	a_cfg_src: assert property (strap_valid && cfg_loaded |=>
		low_power_link_state_disable == $past(cfg_low_power_link_state_disable)) else $error("bad lpm");
	a_pin_route: assert property (memory_mode_en |-> shared_serial_data_pin_oe == mem_sda_oe)
		else $error("bad route");
	a_valid_soon: assert property (s_rel |-> ##[1:7] strap_valid) else $error("no strap");
endmodule // hssp_sva
bind hssp_top hssp_sva u_sva (.*);

// file: tb/hssp_far.sv
// partner: far-side host or memory pin with the pin's pull-down
`timescale 1ns/10ps
module hssp_far (
	input wire logic drv, val, dut_o, dut_oe,
	output logic pin
);
	// device drive wins, then the far side, else the pull-down holds it low
	assign pin = dut_oe ? dut_o : (drv ? val : 1'b0);
endmodule // hssp_far

// file: tb/hssp_top_bench.sv
// bench: strap capture, pin routing and upstream status checks
`timescale 1ns/10ps
module hssp_top_bench;
	logic clk = 0, reset_n = 0, interface_mode_select = 1, power_mgmt_strap_addr_bit = 0;
	logic cfg_loaded = 0, cfg_low_power_link_state_disable = 0, port_pwr_request = 0;
	logic up_connected = 0, up_high_speed = 0, up_super_speed = 0, up_suspended = 0;
	logic mem_scl_o = 0, mem_scl_oe = 0, mem_sda_o = 0, mem_sda_oe = 0, x = 0, ls = 1;
	logic host_scl_o = 0, host_scl_oe = 0, host_sda_o = 0, host_sda_oe = 0, drv = 1, dv = 1, sk = 0;
	logic shared_serial_clock_pin_i, shared_serial_clock_pin_o, shared_serial_clock_pin_oe;
	logic shared_serial_data_pin_i, shared_serial_data_pin_o, shared_serial_data_pin_oe;
	logic engine_scl_i, engine_sda_i, memory_mode_en, host_mode_en, strap_valid, full_power_mgmt;
	logic high_speed_suspend_out, super_speed_suspend_out, high_speed_link_out;
	logic super_speed_link_out, low_power_link_state_disable, downstream_power_enable;
	logic [6:0] mem_bus_addr, slave_addr;
	logic [7:0] mem_start_addr;
	logic [13:0] q[$];
	int error_cnt = 0, checks_done = 0, cyc = 0, seed = 13785;
	wire [13:0] obs = {slave_addr, full_power_mgmt, low_power_link_state_disable,
		high_speed_suspend_out, super_speed_suspend_out, high_speed_link_out,
		super_speed_link_out, downstream_power_enable};
	hssp_top dut (.*);
	hssp_far u_scl (.drv(1'b1), .val(sk), .dut_o(shared_serial_clock_pin_o),
		.dut_oe(shared_serial_clock_pin_oe), .pin(shared_serial_clock_pin_i));
	hssp_far u_sda (.drv(drv), .val(dv), .dut_o(shared_serial_data_pin_o),
		.dut_oe(shared_serial_data_pin_oe), .pin(shared_serial_data_pin_i));
	initial forever #12.5 clk = ~clk;
	always #100 sk = ~sk;
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [13:0] e, input logic [13:0] o);
		checks_done++;
		if (e !== o) begin
			error_cnt++;
			$display("[ERR] %0t exp %h got %h", $time, e, o);
		end
	endtask
	// random link state, engines, mode and strap pins; expected note queued
	task automatic step(input logic [31:0] r);
		{up_connected, up_high_speed, up_super_speed, up_suspended} = r[3:0];
		{port_pwr_request, cfg_loaded, cfg_low_power_link_state_disable} = r[6:4];
		{mem_scl_o, mem_scl_oe, mem_sda_o, mem_sda_oe} = r[10:7];
		{host_scl_o, host_scl_oe, host_sda_o, host_sda_oe} = r[14:11];
		{power_mgmt_strap_addr_bit, dv, interface_mode_select} = r[17:15];
		q.push_back({6'h23, x, ~x, r[5] ? r[4] : ls, r[3] & r[2] & ~r[1] & r[0],
			r[3] & r[1] & r[0], r[3] & r[2] & ~r[1], r[3] & r[1], ~x & r[6]});
		@(negedge clk);
	endtask
	always @(posedge clk) begin
		if (q.size() > 0) begin
			#1;
			chk(q.pop_front(), obs);
		end
	end
	always @(posedge clk) begin
		if (++cyc > 1000) begin
			error_cnt++;
			tally_and_finish;
		end
	end
	initial begin
		for (int t = 0; t < 2; t++) begin
			reset_n = 0;
			drv = 1;
			x = t[0];
			ls = ~t[0];
			dv = ls;
			power_mgmt_strap_addr_bit = x;
			interface_mode_select = t[0];
			repeat (2) @(negedge clk);
			reset_n = 1;
			@(negedge clk);
			chk({13'h0, shared_serial_data_pin_oe | shared_serial_clock_pin_oe}, 14'h0);
			repeat (7) @(negedge clk);
			drv = 0;
			chk({13'h0, strap_valid}, 14'h1);
			chk({12'h0, memory_mode_en, host_mode_en}, {12'h0, t[0], ~t[0]});
			chk({7'h0, mem_bus_addr}, 14'h50);
			chk({6'h0, mem_start_addr}, 14'h0);
			repeat (60) step($random(seed));
			$display("test %0d done", t);
		end
		tally_and_finish;
	end
endmodule // hssp_top_bench
